// File: ins_interrupt_sequencer.sv
// Interrupt request arbitration, vector fetch and register slave.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module ins_interrupt_sequencer
  import ins_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int PRIO_W = 3
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU core sequencer.
  input wire ins_cpu_in_t cpu_in,
  output ins_jump_t jump_out,
  output logic seq_busy,
  output logic stack_select,
  // Vector fetch port.
  output logic vf_req,
  output logic [31:0] vf_addr,
  input wire logic vf_ack,
  input wire logic [31:0] vf_data,
  // Interrupt sources.
  input wire logic [NSRC-3:0] periph_req,
  input wire logic wdt_underflow,
  input wire logic vcc_above_in,
  // System outputs.
  output logic sys_reset_req,
  output logic irq
);

  // Register state.
  logic [2:0] ctrl_r;
  logic [NSRC*PRIO_W-1:0] prio_r;
  logic [31:0] vbase_r;
  logic low_voltage_detect_flag_r;
  logic [INS_EVT_W-1:0] istat_r;
  logic [INS_EVT_W-1:0] imask_r;
  // AXI slave state.
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // Sequencer state.
  ins_state_t st_r;
  logic [7:0] num_r;
  logic is_hw_r;
  logic is_brk_r;
  logic [$clog2(NSRC)-1:0] hw_idx_r;
  logic [31:0] vf_addr_r;
  logic vf_req_r;
  logic jump_valid_r;
  logic [31:0] jump_addr_r;
  logic stack_r;
  logic stack_saved_r;
  logic sys_reset_r;
  // Supply comparator synchroniser and level.
  logic [2:0] vcc_sync_r;
  logic vmf_r;
  // Combinational nets.
  logic wr_fire;
  logic [31:0] wmask;
  logic [31:0] wmerge;
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] set_vec;
  logic [NSRC-1:0] sw_clr;
  logic [NSRC-1:0] hw_clr;
  logic [PRIO_W-1:0] best_prio;
  logic [$clog2(NSRC)-1:0] best_idx;
  logic lvd_rise;
  logic wdt_irq_set;
  logic lvd_irq_set;
  logic take_brk;
  logic take_swi;
  logic take_hw;
  logic brk_fallback;
  logic [INS_EVT_W-1:0] evt;
  logic [7:0] hw_num;

  // Byte-enable mask and merged write data.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{w_strb_r[b]}};
    end
    wmerge = w_data_r & wmask;
  end

  // A register write happens once both address and data are held.
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

  // Write address and data capture in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;

  // Write response with error for an unmapped address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= INS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      if (aw_addr_r[7:5] == 3'h0 && aw_addr_r[1:0] == 2'h0) begin
        bresp_r <= INS_RESP_OKAY;
      end else begin
        bresp_r <= INS_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Control, priority, vector base and mask registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= INS_CTRL_RST;
      prio_r <= INS_PRIO_RST[NSRC*PRIO_W-1:0];
      vbase_r <= INS_VBASE_RST;
      imask_r <= '0;
    end else if (wr_fire) begin
      if (aw_addr_r == INS_OFF_CTRL) begin
        ctrl_r[INS_CTRL_GIE] <= wmask[INS_CTRL_GIE] ?
          w_data_r[INS_CTRL_GIE] : ctrl_r[INS_CTRL_GIE];
        ctrl_r[INS_CTRL_LVIE] <= wmask[INS_CTRL_LVIE] ?
          w_data_r[INS_CTRL_LVIE] : ctrl_r[INS_CTRL_LVIE];
        // Once set, only reset returns the select to interrupt mode.
        ctrl_r[INS_CTRL_WRS] <= ctrl_r[INS_CTRL_WRS] |
          wmerge[INS_CTRL_WRS]; // [R10]
      end else if (aw_addr_r == INS_OFF_PRIO) begin
        prio_r <= (prio_r & ~wmask[NSRC*PRIO_W-1:0]) |
          wmerge[NSRC*PRIO_W-1:0];
      end else if (aw_addr_r == INS_OFF_VBASE) begin
        vbase_r <= ((vbase_r & ~wmask) | wmerge) & 32'hFFFF_FFFC;
      end else if (aw_addr_r == INS_OFF_IMASK) begin
        imask_r <= (imask_r & ~wmask[INS_EVT_W-1:0]) |
          wmerge[INS_EVT_W-1:0];
      end
    end
  end

  // Software clears a request flag by writing zero to its bit.
  assign sw_clr = (wr_fire && aw_addr_r == INS_OFF_REQ) ?
    (wmask[NSRC-1:0] & ~w_data_r[NSRC-1:0]) : '0; // [R8]

  // Three-stage synchroniser on the supply comparator.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vcc_sync_r <= 3'h0;
      vmf_r <= 1'b0;
    end else begin
      vcc_sync_r <= {vcc_sync_r[1:0], vcc_above_in};
      if (vcc_sync_r[1] == vcc_sync_r[2]) begin
        vmf_r <= vcc_sync_r[2];
      end
    end
  end

  // Recovery is a settled rise of the comparator level.
  assign lvd_rise = (vcc_sync_r[1] == vcc_sync_r[2]) && vcc_sync_r[2] &&
    !vmf_r; // [R11]

  // Detection flag: set on recovery, cleared by writing zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_voltage_detect_flag_r <= 1'b0;
    end else if (lvd_rise) begin
      low_voltage_detect_flag_r <= 1'b1; // [R11]
    end else if (wr_fire && aw_addr_r == INS_OFF_LVD &&
                 wmask[INS_LVD_LOW_VOLTAGE_DETECT_FLAG] && !w_data_r[INS_LVD_LOW_VOLTAGE_DETECT_FLAG]) begin
      low_voltage_detect_flag_r <= 1'b0;
    end
  end

  // Watchdog underflow routes to reset or to an interrupt request.
  assign wdt_irq_set = wdt_underflow && !ctrl_r[INS_CTRL_WRS]; // [R9]
  assign lvd_irq_set = lvd_rise && ctrl_r[INS_CTRL_LVIE]; // [R11]
  assign set_vec = {lvd_irq_set, wdt_irq_set, periph_req};

  // System reset request pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_r <= 1'b0;
    end else begin
      sys_reset_r <= wdt_underflow && ctrl_r[INS_CTRL_WRS]; // [R9]
    end
  end

  assign sys_reset_req = sys_reset_r;

  // One sticky request flag per source.
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_flag
      assign hw_clr[gi] = (st_r == INS_ST_JUMP) && is_hw_r &&
        (hw_idx_r == ($clog2(NSRC))'(gi)); // [R7]
      ins_req_flag u_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_pulse(set_vec[gi]),
        .hw_clr(hw_clr[gi]),
        .sw_clr(sw_clr[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // Highest programmed level wins; level zero never requests.
  always_comb begin
    best_prio = '0;
    best_idx = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (flags[i] && prio_r[i*PRIO_W +: PRIO_W] > best_prio) begin
        best_prio = prio_r[i*PRIO_W +: PRIO_W]; // [R12]
        best_idx = i[$clog2(NSRC)-1:0];
      end
    end
  end

  // Requests are only taken at an instruction boundary while idle.
  assign take_brk = (st_r == INS_ST_IDLE) && cpu_in.boundary &&
    cpu_in.brk_exec;
  assign take_swi = (st_r == INS_ST_IDLE) && cpu_in.boundary &&
    !cpu_in.brk_exec && cpu_in.swi_req;
  assign take_hw = (st_r == INS_ST_IDLE) && cpu_in.boundary &&
    !cpu_in.brk_exec && !cpu_in.swi_req && cpu_in.ienable &&
    ctrl_r[INS_CTRL_GIE] && (best_prio != '0); // [R12]
  assign hw_num = INS_HW_NUM_BASE + 8'(best_idx);
  assign brk_fallback = (st_r == INS_ST_FETCH) && vf_ack && is_brk_r &&
    (vf_data[31:24] == INS_BRK_BLANK); // [R5]

  // Vector fetch and jump sequencer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= INS_ST_IDLE;
      num_r <= 8'h00;
      is_hw_r <= 1'b0;
      is_brk_r <= 1'b0;
      hw_idx_r <= '0;
      vf_addr_r <= 32'h0000_0000;
      vf_req_r <= 1'b0;
      jump_valid_r <= 1'b0;
      jump_addr_r <= 32'h0000_0000;
    end else begin
      jump_valid_r <= 1'b0;
      case (st_r)
        INS_ST_IDLE: begin
          if (take_brk) begin
            is_brk_r <= 1'b1;
            is_hw_r <= 1'b0;
            vf_addr_r <= INS_BRK_FIX_ADDR;
            vf_req_r <= 1'b1;
            st_r <= INS_ST_FETCH;
          end else if (take_swi || take_hw) begin
            is_brk_r <= 1'b0;
            is_hw_r <= take_hw;
            hw_idx_r <= best_idx;
            num_r <= take_hw ? hw_num : cpu_in.swi_num;
            // Each vector holds a 4-byte handler address.
            vf_addr_r <= vbase_r + 32'(INS_VEC_BYTES) *
              {24'h000000, take_hw ? hw_num : cpu_in.swi_num}; // [R4]
            vf_req_r <= 1'b1;
            st_r <= INS_ST_FETCH;
          end
        end
        INS_ST_FETCH: begin
          if (vf_ack) begin
            vf_req_r <= 1'b0;
            if (brk_fallback) begin
              // Blank break vector: use software interrupt 0 instead.
              is_brk_r <= 1'b0;
              num_r <= 8'h00;
              vf_addr_r <= vbase_r; // [R5]
              st_r <= INS_ST_REFETCH;
            end else begin
              jump_addr_r <= vf_data; // [R4]
              jump_valid_r <= 1'b1;
              st_r <= INS_ST_JUMP;
            end
          end
        end
        INS_ST_REFETCH: begin
          vf_req_r <= 1'b1;
          st_r <= INS_ST_FETCH;
        end
        INS_ST_JUMP: begin
          st_r <= INS_ST_IDLE;
        end
        default: begin
          st_r <= INS_ST_IDLE;
        end
      endcase
    end
  end

  // Stack select flag: saved and cleared for low numbers only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_r <= 1'b0;
      stack_saved_r <= 1'b0;
    end else if ((take_swi && cpu_in.swi_num < INS_SWI_STACK_LIMIT) ||
                 take_hw) begin
      stack_saved_r <= stack_r; // [R1]
      stack_r <= 1'b0; // [R1]
    end else if (take_swi) begin
      stack_r <= stack_r; // [R3]
    end else if (cpu_in.reti) begin
      stack_r <= stack_saved_r; // [R2]
    end else if (cpu_in.stack_wr) begin
      stack_r <= cpu_in.stack_wdata;
    end
  end

  // Sticky event status, write one to clear; new events win.
  assign evt = {brk_fallback, lvd_rise, wdt_underflow,
    st_r == INS_ST_JUMP};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= '0;
    end else if (wr_fire && aw_addr_r == INS_OFF_ISTAT) begin
      istat_r <= (istat_r & ~wmerge[INS_EVT_W-1:0]) | evt;
    end else begin
      istat_r <= istat_r | evt;
    end
  end

  assign irq = |(istat_r & imask_r);

  // Read channel with register decode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= INS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= INS_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      if (s_axi_araddr == INS_OFF_CTRL) begin
        rdata_r <= {29'h0, ctrl_r};
      end else if (s_axi_araddr == INS_OFF_REQ) begin
        rdata_r <= 32'(flags);
      end else if (s_axi_araddr == INS_OFF_PRIO) begin
        rdata_r <= 32'(prio_r);
      end else if (s_axi_araddr == INS_OFF_VBASE) begin
        rdata_r <= vbase_r;
      end else if (s_axi_araddr == INS_OFF_LVD) begin
        rdata_r <= {30'h0, low_voltage_detect_flag_r, vmf_r}; // [R11]
      end else if (s_axi_araddr == INS_OFF_ISTAT) begin
        rdata_r <= 32'(istat_r);
      end else if (s_axi_araddr == INS_OFF_IMASK) begin
        rdata_r <= 32'(imask_r);
      end else if (s_axi_araddr == INS_OFF_CORE) begin
        rdata_r <= {16'h0, num_r, 5'h0, st_r != INS_ST_IDLE,
          stack_saved_r, stack_r};
      end else begin
        rresp_r <= INS_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Core-facing outputs.
  assign jump_out.valid = jump_valid_r;
  assign jump_out.addr = jump_addr_r;
  assign jump_out.num = num_r;
  assign seq_busy = (st_r != INS_ST_IDLE);
  assign stack_select = stack_r;
  assign vf_req = vf_req_r;
  assign vf_addr = vf_addr_r;

endmodule // ins_interrupt_sequencer

// File: ins_interrupt_sequencer_tb_top.sv
// Self-checking testbench of the interrupt sequencer.
`timescale 1ns/1ps
module ins_interrupt_sequencer_tb_top import ins_pkg::*;;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, seq_busy, stack_select, vf_req, vf_ack;
  logic sys_reset_req, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, vf_addr, vf_data, rd_v;
  ins_cpu_in_t cpu_in = '0;
  ins_jump_t jump_out;
  logic [5:0] periph_req = 6'h00;
  logic wdt_underflow = 1'h0;
  logic vcc_above_in = 1'h0;
  logic brk_blank = 1'h0;
  int fail_count = 0;
  int total_checks = 0;

  ins_interrupt_sequencer dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_in,
    .jump_out, .seq_busy, .stack_select, .vf_req, .vf_addr, .vf_ack,
    .vf_data, .periph_req, .wdt_underflow, .vcc_above_in, .sys_reset_req,
    .irq);
  ins_vec_mem_model model_u (.aclk, .vf_req, .vf_addr, .vf_ack, .vf_data,
    .brk_blank);

  // Clock of 100 ns period.
  always #50 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bus write: both channels offered together, response awaited.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    rd(a);
    chk(rd_v & m, e);
  endtask
  // Core request held for one boundary edge while the sequencer is idle.
  task automatic core_req(input logic break_instruction, input logic swi,
                          input logic [7:0] num);
    @(posedge aclk);
    cpu_in.boundary <= 1'h1;
    cpu_in.brk_exec <= break_instruction;
    cpu_in.swi_req <= swi;
    cpu_in.swi_num <= num;
    @(posedge aclk);
    cpu_in.boundary <= 1'h0;
    cpu_in.brk_exec <= 1'h0;
    cpu_in.swi_req <= 1'h0;
  endtask
  task automatic jwait(input logic [31:0] ea, input logic [7:0] en);
    int n = 0;
    while (!jump_out.valid && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(jump_out.valid), 32'h1);
    chk(jump_out.addr, ea);
    chk(32'(jump_out.num), 32'(en));
  endtask
  task automatic pulse_core_reti;
    @(posedge aclk);
    cpu_in.reti <= 1'h1;
    @(posedge aclk);
    cpu_in.reti <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  task automatic sc_swi;
    wr(INS_OFF_VBASE, 32'h0000_0100);
    @(posedge aclk);
    cpu_in.stack_wr <= 1'h1;
    cpu_in.stack_wdata <= 1'h1;
    @(posedge aclk);
    cpu_in.stack_wr <= 1'h0;
    core_req(1'h0, 1'h1, 8'h7F);
    jwait(32'h8000_02FC, 8'h7F);
    chk(32'(stack_select), 32'h0);
    pulse_core_reti();
    chk(32'(stack_select), 32'h1);
    core_req(1'h0, 1'h1, 8'h80);
    jwait(32'h8000_0300, 8'h80);
    chk(32'(stack_select), 32'h1);
  endtask
  task automatic sc_brk;
    core_req(1'h1, 1'h0, 8'h00);
    jwait(32'h0000_7770, 8'h80);
    brk_blank <= 1'h1;
    core_req(1'h1, 1'h0, 8'h00);
    jwait(32'h8000_0100, 8'h00);
  endtask
  task automatic sc_hw;
    wr(INS_OFF_PRIO, 32'h0000_002A);
    @(posedge aclk);
    periph_req <= 6'h03;
    @(posedge aclk);
    periph_req <= 6'h00;
    rchk(INS_OFF_REQ, 32'h3, 32'hFF);
    wr(INS_OFF_CTRL, 32'h1);
    core_req(1'h0, 1'h0, 8'h00);
    jwait(32'h8000_0184, 8'h21);
    rchk(INS_OFF_REQ, 32'h1, 32'hFF);
    wr(INS_OFF_REQ, 32'h0);
    rchk(INS_OFF_REQ, 32'h0, 32'hFF);
  endtask
  task automatic sc_wdt;
    wr(INS_OFF_IMASK, 32'h2);
    @(posedge aclk);
    wdt_underflow <= 1'h1;
    @(posedge aclk);
    wdt_underflow <= 1'h0;
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1);
    rchk(INS_OFF_REQ, 32'h40, 32'h40);
    wr(INS_OFF_IMASK, 32'h0);
    chk(32'(irq), 32'h0);
    wr(INS_OFF_IMASK, 32'h2);
    wr(INS_OFF_ISTAT, 32'h2);
    chk(32'(irq), 32'h0);
    wr(INS_OFF_REQ, 32'h0);
    wr(INS_OFF_CTRL, 32'h2);
    wr(INS_OFF_CTRL, 32'h0);
    rchk(INS_OFF_CTRL, 32'h2, 32'h2);
    @(posedge aclk);
    wdt_underflow <= 1'h1;
    @(posedge aclk);
    wdt_underflow <= 1'h0;
    @(posedge aclk);
    chk(32'(sys_reset_req), 32'h1);
    rchk(INS_OFF_REQ, 32'h0, 32'h40);
    do_reset();
    rchk(INS_OFF_CTRL, 32'h0, 32'h2);
  endtask
  task automatic sc_lvd;
    wr(INS_OFF_CTRL, 32'h4);
    @(posedge aclk);
    vcc_above_in <= 1'h1;
    repeat (8) @(posedge aclk);
    rchk(INS_OFF_LVD, 32'h3, 32'h3);
    rchk(INS_OFF_REQ, 32'h80, 32'h80);
    rchk(INS_OFF_ISTAT, 32'h4, 32'h4);
    rd(8'h40);
    chk(32'(rsp), 32'(INS_RESP_SLVERR));
    wr(8'h40, 32'h0);
    chk(32'(rsp), 32'(INS_RESP_SLVERR));
  endtask

  // Main sequence.
  initial begin
    cpu_in.ienable = 1'h1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(INS_OFF_CTRL, 32'h0, 32'h7);
    sc_swi();
    sc_brk();
    sc_hw();
    sc_wdt();
    sc_lvd();
    test_done();
  end
  // Watchdog that cuts a hang short.
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    test_done();
  end
endmodule // ins_interrupt_sequencer_tb_top

// File: ins_pkg.sv
// Package of constants, types and register map of the interrupt sequencer.
// Functional notes
// R1 - Swi 0-127 saves then clears stack flag
// R2 - Return restores the saved stack flag
// R3 - Swi 128-255 keeps stack selection unchanged
// R4 - Fetch 4-byte vector, jump to its address
// R5 - Break byte all ones uses swi 0
// R6 - Request flag set, held until accepted
// R7 - Accepted jump clears that request flag
// R8 - Software writes 0 to clear, never 1
// R9 - Watchdog underflow: interrupt or reset per select
// R10 - Watchdog reset select sticks until reset
// R11 - Supply recovery sets both flags, optional request
// R12 - Highest priority pending taken at boundaries
package ins_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] INS_OFF_CTRL = 8'h00;
  localparam logic [7:0] INS_OFF_REQ = 8'h04;
  localparam logic [7:0] INS_OFF_PRIO = 8'h08;
  localparam logic [7:0] INS_OFF_VBASE = 8'h0C;
  localparam logic [7:0] INS_OFF_LVD = 8'h10;
  localparam logic [7:0] INS_OFF_ISTAT = 8'h14;
  localparam logic [7:0] INS_OFF_IMASK = 8'h18;
  localparam logic [7:0] INS_OFF_CORE = 8'h1C;

  // Field positions in the control and low-voltage registers.
  localparam int INS_CTRL_GIE = 0;
  localparam int INS_CTRL_WRS = 1;
  localparam int INS_CTRL_LVIE = 2;
  localparam int INS_LVD_VMF = 0;
  localparam int INS_LVD_LOW_VOLTAGE_DETECT_FLAG = 1;

  // Event bits of the interrupt status register.
  localparam int INS_EVT_W = 4;
  localparam int INS_EVT_ACCEPT = 0;
  localparam int INS_EVT_WDT = 1;
  localparam int INS_EVT_LVD = 2;
  localparam int INS_EVT_BRKFB = 3;

  // Values after reset.
  localparam logic [2:0] INS_CTRL_RST = 3'h0;
  localparam logic [31:0] INS_VBASE_RST = 32'h0000_0000;
  localparam logic [31:0] INS_PRIO_RST = 32'h0000_0000;

  // Vector and break constants.
  localparam logic [31:0] INS_BRK_FIX_ADDR = 32'h0FFF_FFE4;
  localparam logic [7:0] INS_BRK_BLANK = 8'hFF;
  localparam logic [7:0] INS_SWI_STACK_LIMIT = 8'h80;
  localparam logic [7:0] INS_HW_NUM_BASE = 8'h20;
  localparam int INS_VEC_BYTES = 4;
  localparam logic [1:0] INS_RESP_OKAY = 2'h0;
  localparam logic [1:0] INS_RESP_SLVERR = 2'h2;

  // Sequencer states.
  typedef enum logic [1:0] {
    INS_ST_IDLE,
    INS_ST_FETCH,
    INS_ST_REFETCH,
    INS_ST_JUMP
  } ins_state_t;

  // Requests from the CPU core sequencer.
  typedef struct packed {
    logic boundary;
    logic ienable;
    logic swi_req;
    logic [7:0] swi_num;
    logic brk_exec;
    logic reti;
    logic stack_wr;
    logic stack_wdata;
  } ins_cpu_in_t;

  // Jump answer to the CPU core sequencer.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [7:0] num;
  } ins_jump_t;

endpackage

// File: ins_req_flag.sv
// One sticky interrupt request flag with hardware and software clear.
`timescale 1ns/1ps
module ins_req_flag
  import ins_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Set and clear strobes.
  input wire logic set_pulse,
  input wire logic hw_clr,
  input wire logic sw_clr,
  // Flag state.
  output logic flag
);

  logic flag_r;
  logic flag_nxt;

  // A new request wins over a clear in the same cycle.
  always_comb begin
    if (set_pulse) begin
      flag_nxt = 1'b1; // [R6]
    end else if (hw_clr || sw_clr) begin
      flag_nxt = 1'b0; // [R7] [R8]
    end else begin
      flag_nxt = flag_r; // [R6]
    end
  end

  // Flag register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule // ins_req_flag

// File: ins_seq_chk.sv
// Checker of the interrupt sequencer core and vector fetch ports.
`timescale 1ns/1ps
module ins_seq_chk
  import ins_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Core side.
  input wire ins_cpu_in_t cpu_in,
  input wire ins_jump_t jump_out,
  input wire logic seq_busy,
  input wire logic stack_select,
  // Vector fetch.
  input wire logic vf_req,
  input wire logic [31:0] vf_addr,
  input wire logic vf_ack,
  input wire logic [31:0] vf_data,
  // Watchdog.
  input wire logic wdt_underflow,
  input wire logic sys_reset_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  logic blank;
  // A take is an idle sequencer seeing a boundary with a core request.
  assign take = cpu_in.boundary && !seq_busy
    && (cpu_in.swi_req || cpu_in.brk_exec);
  assign blank = (vf_addr == INS_BRK_FIX_ADDR)
    && (vf_data[31:24] == INS_BRK_BLANK);
  property p_swi_low;
    take && !cpu_in.brk_exec && cpu_in.swi_num < INS_SWI_STACK_LIMIT
      |=> !stack_select;
  endproperty
  a_swi_low: assert property (p_swi_low) else $error("flag kept");
  property p_swi_high;
    take && !cpu_in.brk_exec && cpu_in.swi_num >= INS_SWI_STACK_LIMIT
      |=> $stable(stack_select)[*3];
  endproperty
  a_swi_high: assert property (p_swi_high) else $error("flag moved");
  property p_fetch;
    take |=> vf_req && seq_busy;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch");
  property p_brk_addr;
    take && cpu_in.brk_exec |=> vf_addr == INS_BRK_FIX_ADDR;
  endproperty
  a_brk_addr: assert property (p_brk_addr) else $error("brk addr");
  property p_vf_hold;
    vf_req && !vf_ack |=> vf_req && $stable(vf_addr);
  endproperty
  a_vf_hold: assert property (p_vf_hold) else $error("fetch dropped");
  property p_jump;
    vf_req && vf_ack && !blank
      |=> jump_out.valid && jump_out.addr == $past(vf_data);
  endproperty
  a_jump: assert property (p_jump) else $error("bad jump");
  property p_fallback;
    vf_req && vf_ack && blank |=> !jump_out.valid
      ##[1:4] (vf_req && vf_addr != INS_BRK_FIX_ADDR);
  endproperty
  a_fallback: assert property (p_fallback) else $error("no refetch");
  property p_jump_pulse;
    jump_out.valid |=> !jump_out.valid;
  endproperty
  a_jump_pulse: assert property (p_jump_pulse) else $error("long jump");
  property p_rst_cause;
    sys_reset_req |-> $past(wdt_underflow) ##1 !sys_reset_req;
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("bad reset");
  // Main scenarios reached.
  c_brk: cover property (take && cpu_in.brk_exec);
  c_blank: cover property (vf_ack && blank);
  c_reset: cover property (sys_reset_req);
endmodule // ins_seq_chk

bind ins_interrupt_sequencer ins_seq_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .cpu_in(cpu_in), .jump_out(jump_out),
  .seq_busy(seq_busy), .stack_select(stack_select), .vf_req(vf_req),
  .vf_addr(vf_addr), .vf_ack(vf_ack), .vf_data(vf_data),
  .wdt_underflow(wdt_underflow), .sys_reset_req(sys_reset_req)
);

// File: ins_vec_mem_model.sv
// Vector memory partner that answers the sequencer's vector fetches.
`timescale 1ns/1ps
module ins_vec_mem_model
  import ins_pkg::*;
(
  // Clock.
  input wire logic aclk,
  // Fetch port.
  input wire logic vf_req,
  input wire logic [31:0] vf_addr,
  output logic vf_ack,
  output logic [31:0] vf_data,
  // Break word reads with an all-ones top byte when high.
  input wire logic brk_blank
);
  logic slow;
  logic [1:0] wait_cnt;
  // Start quiet with a prompt first reply.
  initial begin
    vf_ack = 1'h0;
    vf_data = 32'h5A5A_5A5A;
    slow = 1'h0;
    wait_cnt = 2'h0;
  end
  // Answers alternate prompt and slow; data toggles outside an answer.
  always @(posedge aclk) begin
    vf_ack <= 1'h0;
    vf_data <= ~vf_data;
    if (vf_req && !vf_ack) begin
      if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
        vf_ack <= 1'h1;
        vf_data <= (vf_addr != INS_BRK_FIX_ADDR) ? vf_addr ^ 32'h8000_0000
          : (brk_blank ? 32'hFF00_0000 : 32'h0000_7770);
        slow <= ~slow;
        wait_cnt <= 2'h0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule // ins_vec_mem_model
